/* File: include/i2c_word_defines.svh */
// Function
// RULE1: Idle bus has data and clock high, pulled up, driven by nobody.
// RULE2: Data falling while clock high is START and begins a transaction.
// RULE3: Data rising while clock high is STOP and frees the bus.
// RULE4: Device pulls data low for whole high phase of acknowledge pulse.
// RULE5: Master clocks each acknowledge slot and releases data during it.
// RULE6: Any master must leave data undriven during every acknowledge cycle.
// RULE7: Device is a receive-only slave, never drives data bytes.
// RULE8: Seven-bit address then write bit zero; acknowledge on address match.
// RULE9: Upper six address bits are fixed at 001011.
// RULE10: Select pin low gives 0010111, high gives 0010110.
// RULE11: First data byte acknowledged then latched into high input register.
// RULE12: Second data byte acknowledged then latched into low input register.
// RULE13: Master closes write-word with STOP after second acknowledge.
// RULE14: Word bits 15:12 octave, 11:2 fine frequency, 1:0 output config.
// RULE15: Input registers clear to zero at power-up.
// RULE16: Mismatch or read bit: no acknowledge, ignore bus until next START.
// RULE17: Mid-transaction START or STOP drops unacknowledged byte, keeps registers.
`ifndef I2C_WORD_DEFINES_SVH
`define I2C_WORD_DEFINES_SVH
`define ADDR_PREFIX 6'h0b
`define DIR_WRITE 1'h0
`define BYTE_LAST_BIT 3'h7
`define WORD_RESET 8'h00
`define OCTAVE_HI 15
`define OCTAVE_LO 12
`define FINE_HI 11
`define FINE_LO 2
`define CFG_HI 1
`define CFG_LO 0
`endif

/* File: include/i2c_word_pkg.sv */
package i2c_word_pkg;
   typedef enum logic [2:0] {IDLE, ADDR, DATA_HI, DATA_LO, ACK, IGNORE} rx_state_e;
endpackage : i2c_word_pkg

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Pin and filtered level
   input wire logic pinIn,
   output logic level
);
   logic stage1_ff;
   logic stage2_ff;
   logic stage3_ff;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stage1_ff <= 1'h1;
         stage2_ff <= 1'h1;
         stage3_ff <= 1'h1;
         level <= 1'h1;
      end else begin
         stage1_ff <= pinIn;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         if (stage2_ff == stage3_ff) begin
            level <= stage3_ff;
         end
      end
   end
endmodule : pin_sync

/* File: hdl/i2c_write_word_receiver.sv */
`timescale 1ns/1ps
`include "i2c_word_defines.svh"
module i2c_write_word_receiver
   import i2c_word_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Two-wire bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Address select strap
   input wire logic addrSel,
   // Oscillator settings
   output logic [3:0] octave_code,
   output logic [9:0] fineFreq,
   output logic [1:0] output_config,
   output logic wordValid
);
   logic scl;
   logic sda;
   logic sclPrev_ff;
   logic sdaPrev_ff;
   rx_state_e state_ff;
   rx_state_e nxt_state;
   rx_state_e afterAck_ff;
   logic [7:0] shift_ff;
   logic [2:0] bitCnt_ff;
   logic [7:0] hiReg_ff;
   logic [7:0] loReg_ff;
   logic selLevel;
   logic ackDrive_ff;
   logic [1:0] ackKind_ff;
   logic valid_ff;

   pin_sync u_scl (.clock(clock), .rst_b(rst_b), .pinIn(sclIn), .level(scl));
   pin_sync u_sda (.clock(clock), .rst_b(rst_b), .pinIn(sdaIn), .level(sda));
   pin_sync u_sel (.clock(clock), .rst_b(rst_b), .pinIn(addrSel), .level(selLevel));

   wire sclRise = scl & ~sclPrev_ff;
   wire sclFall = ~scl & sclPrev_ff;
   wire startCond = sclPrev_ff & scl & sdaPrev_ff & ~sda; // RULE2
   wire stopCond = sclPrev_ff & scl & ~sdaPrev_ff & sda; // RULE3
   wire [7:0] rxByte = {shift_ff[6:0], sda};
   wire [6:0] myAddr = {`ADDR_PREFIX, ~selLevel}; // RULE9 RULE10
   wire addrHit = (rxByte[7:1] == myAddr) && (rxByte[0] == `DIR_WRITE); // RULE8
   wire byteDone = sclRise && (bitCnt_ff == `BYTE_LAST_BIT);
   wire inByte = (state_ff == ADDR) || (state_ff == DATA_HI) || (state_ff == DATA_LO);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sclPrev_ff <= 1'h1;
         sdaPrev_ff <= 1'h1;
      end else begin
         sclPrev_ff <= scl;
         sdaPrev_ff <= sda;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= IDLE;
         afterAck_ff <= IDLE;
         shift_ff <= `WORD_RESET;
         bitCnt_ff <= 3'h0;
         ackDrive_ff <= 1'h0;
         ackKind_ff <= 2'h0;
         hiReg_ff <= `WORD_RESET; // RULE15
         loReg_ff <= `WORD_RESET; // RULE15
         valid_ff <= 1'h0;
      end else begin
         valid_ff <= 1'h0;
         if (startCond) begin
            // Abandon partial byte, keep latched registers
            state_ff <= ADDR; // RULE2 RULE17
            bitCnt_ff <= 3'h0;
            ackDrive_ff <= 1'h0;
         end else if (stopCond) begin
            state_ff <= IDLE; // RULE3 RULE17
            ackDrive_ff <= 1'h0;
         end else begin
            case (state_ff)
               ADDR, DATA_HI, DATA_LO: begin
                  if (sclRise) begin
                     shift_ff <= rxByte;
                     bitCnt_ff <= bitCnt_ff + 3'h1;
                  end
                  if (byteDone) begin
                     if (state_ff == ADDR && !addrHit) begin
                        state_ff <= IGNORE; // RULE16
                     end else begin
                        state_ff <= ACK;
                        afterAck_ff <= nxt_state;
                        ackKind_ff <= (state_ff == ADDR) ? 2'h0 :
                                      (state_ff == DATA_HI) ? 2'h1 : 2'h2;
                     end
                  end
               end
               ACK: begin
                  // Drive low from falling edge through the ack high phase
                  if (sclFall && !ackDrive_ff) begin
                     ackDrive_ff <= 1'h1; // RULE4
                  end else if (sclFall && ackDrive_ff) begin
                     ackDrive_ff <= 1'h0;
                     state_ff <= afterAck_ff;
                     bitCnt_ff <= 3'h0;
                     if (ackKind_ff == 2'h1) begin
                        hiReg_ff <= shift_ff; // RULE11
                     end else if (ackKind_ff == 2'h2) begin
                        loReg_ff <= shift_ff; // RULE12
                        valid_ff <= 1'h1;
                     end
                  end
               end
               IDLE, IGNORE: begin
                  ackDrive_ff <= 1'h0;
               end
               default: begin
                  state_ff <= IDLE;
               end
            endcase
         end
      end
   end

   always_comb begin
      case (state_ff)
         ADDR: nxt_state = DATA_HI;
         DATA_HI: nxt_state = DATA_LO;
         default: nxt_state = IGNORE;
      endcase
   end

   // Open-drain: only ever pulls low, never sends data
   assign sdaOut = 1'h0; // RULE7
   assign sdaOe = ackDrive_ff; // RULE4 RULE7

   wire [15:0] word = {hiReg_ff, loReg_ff};
   assign octave_code = word[`OCTAVE_HI:`OCTAVE_LO]; // RULE14
   assign fineFreq = word[`FINE_HI:`FINE_LO]; // RULE14
   assign output_config = word[`CFG_HI:`CFG_LO]; // RULE14
   assign wordValid = valid_ff;

   // Assertions
   property p_ack_held_high;
      @(posedge clock) disable iff (!rst_b)
         (sdaOe && scl && !startCond && !stopCond) |=> sdaOe;
   endproperty
   a_ack_held_high: assert property (p_ack_held_high) else $error("ack dropped in high"); // RULE4

   property p_idle_no_drive;
      @(posedge clock) disable iff (!rst_b)
         (state_ff == IDLE || state_ff == IGNORE) |-> !sdaOe;
   endproperty
   a_idle_no_drive: assert property (p_idle_no_drive) else $error("driving while idle"); // RULE16

   property p_start_to_addr;
      @(posedge clock) disable iff (!rst_b) startCond |=> state_ff == ADDR;
   endproperty
   a_start_to_addr: assert property (p_start_to_addr) else $error("start missed"); // RULE2

   property p_stop_to_idle;
      @(posedge clock) disable iff (!rst_b) (stopCond && !startCond) |=> state_ff == IDLE;
   endproperty
   a_stop_to_idle: assert property (p_stop_to_idle) else $error("stop missed"); // RULE3

   property p_miss_ignored;
      @(posedge clock) disable iff (!rst_b)
         (state_ff == ADDR && byteDone && !addrHit && !startCond && !stopCond)
         |=> state_ff == IGNORE;
   endproperty
   a_miss_ignored: assert property (p_miss_ignored) else $error("bad address acked"); // RULE16

   property p_hit_acks;
      @(posedge clock) disable iff (!rst_b)
         (state_ff == ADDR && byteDone && addrHit && !startCond && !stopCond)
         |=> state_ff == ACK;
   endproperty
   a_hit_acks: assert property (p_hit_acks) else $error("address not acked"); // RULE8

   property p_valid_from_lo;
      @(posedge clock) disable iff (!rst_b) wordValid |-> $past(state_ff) == ACK;
   endproperty
   a_valid_from_lo: assert property (p_valid_from_lo) else $error("stray word flag"); // RULE12

   property p_lo_with_valid;
      @(posedge clock) disable iff (!rst_b) $changed(loReg_ff) |-> wordValid;
   endproperty
   a_lo_with_valid: assert property (p_lo_with_valid) else $error("low changed"); // RULE12

   property p_regs_stable_outside_ack;
      @(posedge clock) disable iff (!rst_b) ($past(state_ff) != ACK) |-> $stable(hiReg_ff);
   endproperty
   a_regs_stable_outside_ack: assert property (p_regs_stable_outside_ack) // RULE17
      else $error("high register changed");

   property p_start_drops_byte;
      @(posedge clock) disable iff (!rst_b) startCond |=> (bitCnt_ff == 3'h0) && !sdaOe;
   endproperty
   a_start_drops_byte: assert property (p_start_drops_byte) else $error("byte kept"); // RULE17

   property p_map_octave;
      @(posedge clock) disable iff (!rst_b) octave_code == hiReg_ff[7:4];
   endproperty
   a_map_octave: assert property (p_map_octave) else $error("octave mapping"); // RULE14

   property p_map_fine;
      @(posedge clock) disable iff (!rst_b) fineFreq == {hiReg_ff[3:0], loReg_ff[7:2]};
   endproperty
   a_map_fine: assert property (p_map_fine) else $error("fine mapping"); // RULE14

   property p_map_config;
      @(posedge clock) disable iff (!rst_b) output_config == loReg_ff[1:0];
   endproperty
   a_map_config: assert property (p_map_config) else $error("config mapping"); // RULE14

   property p_never_drive_high;
      @(posedge clock) disable iff (!rst_b) sdaOe |-> !sdaOut;
   endproperty
   a_never_drive_high: assert property (p_never_drive_high) else $error("drove high"); // RULE7

   property p_quiet_in_byte;
      @(posedge clock) disable iff (!rst_b) inByte |-> !sdaOe;
   endproperty
   a_quiet_in_byte: assert property (p_quiet_in_byte) else $error("drove during byte"); // RULE7

   c_start: cover property (@(posedge clock) disable iff (!rst_b) startCond);
   c_word: cover property (@(posedge clock) disable iff (!rst_b) wordValid);
   c_ignore: cover property (@(posedge clock) disable iff (!rst_b) state_ff == IGNORE);
   c_ack_high: cover property (@(posedge clock) disable iff (!rst_b) sdaOe && scl);
endmodule : i2c_write_word_receiver

/* File: tb/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
   // Bus pins
   output logic scl,
   output logic sdaLow,
   input wire logic sdaLine
);
   initial begin
      scl = 1'h1;
      sdaLow = 1'h0;
   end
   task automatic start_cond();
      sdaLow = 1'h0;
      #40 scl = 1'h1;
      #40 sdaLow = 1'h1;
      #80 scl = 1'h0;
   endtask : start_cond
   task automatic stop_cond();
      #40 sdaLow = 1'h1;
      #40 scl = 1'h1;
      #80 sdaLow = 1'h0;
      #80;
   endtask : stop_cond
   // Up to eight bits MSB first; a whole byte gets its ack slot
   task automatic send_bits(input logic [7:0] val, input int n, output logic ack,
                            output logic clash);
      ack = 1'h0;
      clash = 1'h0;
      for (int i = 7; i > 7 - n; i--) begin
         #40 sdaLow = ~val[i];
         #40 scl = 1'h1;
         #40 clash |= (sdaLine !== val[i]);
         #40 scl = 1'h0;
      end
      if (n == 8) begin
         #40 sdaLow = 1'h0;
         #200 scl = 1'h1;
         ack = (sdaLine === 1'h0);
         #80 ack &= (sdaLine === 1'h0);
         scl = 1'h0;
         #160;
      end
   endtask : send_bits
endmodule : i2c_master_model

/* File: tb/i2c_write_word_receiver_bench.sv */
`timescale 1ns/1ps
module i2c_write_word_receiver_bench;
   import i2c_word_pkg::*;
   logic clock = 1'h0;
   logic rst_b = 1'h0;
   logic addrSel = 1'h0;
   logic scl, mLow, sdaOut, sdaOe, wordValid;
   logic [3:0] octave_code;
   logic [9:0] fineFreq;
   logic [1:0] output_config;
   logic [15:0] shown, w, prev;
   logic [15:0] expQ[$];
   logic [7:0] badA[3] = '{8'h2c, 8'h2f, 8'h6e};
   logic ackS, clashS;
   int error_cnt = 0;
   int checks_done = 0;
   int seed = 90;
   // Pull-up with wired-low drivers
   wire sdaLine = !(mLow || (sdaOe && !sdaOut));
   assign shown = {octave_code, fineFreq, output_config};
   initial forever #10 clock = ~clock;
   i2c_write_word_receiver i_i2c_write_word_receiver (.clock(clock), .rst_b(rst_b),
      .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
      .octave_code(octave_code), .fineFreq(fineFreq), .output_config(output_config),
      .wordValid(wordValid));
   i2c_master_model i_i2c_master_model (.scl(scl), .sdaLow(mLow), .sdaLine(sdaLine));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int nb,
                       input logic expAck);
      logic ack, clash;
      i_i2c_master_model.start_cond();
      i_i2c_master_model.send_bits(a, 8, ack, clash);
      chk("addr ack", 16'(ack), 16'(expAck));
      for (int k = 0; k < nb; k++) begin
         i_i2c_master_model.send_bits(d[15 - 8 * k -: 8], 8, ack, clash);
         chk("data ack", 16'(ack), 16'(expAck));
         chk("data drive", 16'(clash), 16'h0000);
      end
   endtask : xfer
   // Each completed word is compared with the oldest note
   always @(negedge clock) begin
      if (wordValid === 1'h1) begin
         chk("word", shown, (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx);
      end
   end
   initial begin
      #600000;
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge clock);
      #2 rst_b = 1'h1;
      chk("reset word", shown, 16'h0000);
      repeat (6) @(posedge clock);
      for (int s = 0; s < 2; s++) begin
         @(posedge clock);
         #2 addrSel = s[0];
         w = 16'($random(seed));
         expQ.push_back(w);
         xfer({6'h0b, ~s[0], 1'h0}, w, 2, 1'h1);
         i_i2c_master_model.stop_cond();
      end
      @(posedge clock);
      #2 addrSel = 1'h0;
      prev = w;
      foreach (badA[j]) xfer(badA[j], 16'($random(seed)), 1, 1'h0);
      chk("kept word", shown, prev);
      w = 16'($random(seed));
      expQ.push_back(w);
      xfer(8'h2e, w, 2, 1'h1);
      i_i2c_master_model.stop_cond();
      prev = w;
      w = 16'($random(seed));
      xfer(8'h2e, w, 1, 1'h1);
      i_i2c_master_model.send_bits(w[7:0], 4, ackS, clashS);
      chk("half word", shown, {w[15:8], prev[7:0]});
      chk("partial drive", 16'(clashS), 16'h0000);
      w = 16'($random(seed));
      expQ.push_back(w);
      xfer(8'h2e, w, 2, 1'h1);
      i_i2c_master_model.stop_cond();
      repeat (20) @(posedge clock);
      chk("pending words", 16'(expQ.size()), 16'h0000);
      complete_run();
   end
endmodule : i2c_write_word_receiver_bench
